// >>> logic/mae_core.sv
// Execution core for moves, exchange, arithmetic and logic instructions.
`timescale 1ns/100ps

// Functional notes
// - Bank-0 load sets zero; store keeps flags.
// - Bank-0 store writes accumulator, flags untouched.
// - Immediate bank-0 move only to 0x80-0x87.
// - Exchange swaps accumulator and byte, flags kept.
// - Table read fills R and accumulator, 2 cycles.
// - Add-with-carry updates carry, half carry, zero.
// - Memory-destination add-with-carry writes memory.
// - Immediate add ignores incoming carry.
// - Bank-0 add writes sum to bank-0 byte.
// - Subtract-with-borrow; carry means no borrow.
// - Immediate subtract ignores incoming carry.
// - Decimal adjust converts accumulator, updates carry.
// - Multiply: low to accumulator, high to R.
// - Multiply zero flag follows low byte only.
// - AND writes result, updates zero only.
// - OR writes result, updates zero only.
// - XOR writes result, updates zero only.
module mae_core (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             instr_valid,
    input  mae_pkg::mae_op_t      instr_op,
    input  wire logic [7:0]       instr_addr,
    input  wire logic [7:0]       instr_imm,
    input  wire logic [15:0]      rom_data,
    input  wire logic [8:0]       dbg_idx,
    output logic                  ready_q,
    output logic                  done_q,
    output logic                  reject_q,
    output logic [7:0]            acc_q,
    output logic                  carry_q,
    output logic                  half_carry_flag_q,
    output logic                  zero_result_flag_q,
    output logic [15:0]           rom_addr_q,
    output logic                  rom_rd_q,
    output logic [7:0]            dbg_data_q
);
    typedef enum logic {st_ready, st_finish} mae_st_t;

    mae_alu_if alu_bus ();

    logic [7:0]        mem [mae_pkg::MEM_DEPTH];
    mae_st_t           st_q;
    logic              pend_rom_q;
    logic [15:0]       prod_q;
    logic              bank_q;

    mae_pkg::mae_fn_t  fn;
    mae_pkg::mae_dst_t dst;
    logic              b_imm;
    logic              cin;
    logic              upd_c;
    logic              upd_h;
    logic              upd_z;
    logic              bank0;
    logic              multi;
    logic              bad;
    logic              start;
    logic              finish;
    logic [8:0]        eff_idx;
    logic [7:0]        mem_rd;
    logic              mem_we;
    logic [8:0]        mem_widx;
    logic [7:0]        mem_wdata;
    logic [15:0]       fin_word;

    mae_alu u_alu (
        .port (alu_bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.

    always_comb begin
        fn    = mae_pkg::fn_hold;
        dst   = mae_pkg::dst_none;
        b_imm = 1'b0;
        cin   = carry_q;
        upd_c = 1'b0;
        upd_h = 1'b0;
        upd_z = 1'b0;
        bank0 = 1'b0;
        multi = 1'b0;
        bad   = 1'b0;
        case (instr_op)
            mae_pkg::op_mov_am, mae_pkg::op_bzm_am: begin
                fn    = mae_pkg::fn_pass;
                dst   = mae_pkg::dst_acc;
                upd_z = 1'b1;
                bank0 = (instr_op == mae_pkg::op_bzm_am);
            end
            mae_pkg::op_mov_ma, mae_pkg::op_bzm_ma: begin
                dst   = mae_pkg::dst_mem;
                bank0 = (instr_op == mae_pkg::op_bzm_ma);
            end
            mae_pkg::op_mov_ai: begin
                fn    = mae_pkg::fn_pass;
                b_imm = 1'b1;
                dst   = mae_pkg::dst_acc;
            end
            mae_pkg::op_bzm_mi: begin
                fn    = mae_pkg::fn_pass;
                b_imm = 1'b1;
                dst   = mae_pkg::dst_mem;
                bank0 = 1'b1;
                bad   = (instr_addr < mae_pkg::WREG_FIRST) ||
                        (instr_addr > mae_pkg::WREG_LAST);
            end
            mae_pkg::op_exch, mae_pkg::op_bzx: begin
                fn    = mae_pkg::fn_pass;
                dst   = mae_pkg::dst_swap;
                bank0 = (instr_op == mae_pkg::op_bzx);
            end
            mae_pkg::op_rtr, mae_pkg::op_mult: begin
                multi = 1'b1;
            end
            mae_pkg::op_adc_am, mae_pkg::op_adc_ma, mae_pkg::op_add_am,
            mae_pkg::op_add_ma, mae_pkg::op_bza_ma, mae_pkg::op_add_ai: begin
                fn    = mae_pkg::fn_add;
                b_imm = (instr_op == mae_pkg::op_add_ai);
                cin   = carry_q && ((instr_op == mae_pkg::op_adc_am) ||
                                    (instr_op == mae_pkg::op_adc_ma));
                dst   = ((instr_op == mae_pkg::op_adc_ma) || (instr_op == mae_pkg::op_add_ma) ||
                         (instr_op == mae_pkg::op_bza_ma)) ? mae_pkg::dst_mem
                                                           : mae_pkg::dst_acc;
                bank0 = (instr_op == mae_pkg::op_bza_ma);
                upd_c = 1'b1;
                upd_h = 1'b1;
                upd_z = 1'b1;
            end
            mae_pkg::op_swb_am, mae_pkg::op_swb_ma, mae_pkg::op_sub_am,
            mae_pkg::op_sub_ma, mae_pkg::op_sub_ai: begin
                fn    = mae_pkg::fn_sub;
                b_imm = (instr_op == mae_pkg::op_sub_ai);
                cin   = carry_q || !((instr_op == mae_pkg::op_swb_am) ||
                                     (instr_op == mae_pkg::op_swb_ma));
                dst   = ((instr_op == mae_pkg::op_swb_ma) || (instr_op == mae_pkg::op_sub_ma))
                        ? mae_pkg::dst_mem : mae_pkg::dst_acc;
                upd_c = 1'b1;
                upd_h = 1'b1;
                upd_z = 1'b1;
            end
            mae_pkg::op_dadj: begin
                fn    = mae_pkg::fn_dadj;
                dst   = mae_pkg::dst_acc;
                upd_c = 1'b1;
            end
            mae_pkg::op_and_am, mae_pkg::op_and_ma, mae_pkg::op_and_ai,
            mae_pkg::op_or_am, mae_pkg::op_or_ma, mae_pkg::op_or_ai,
            mae_pkg::op_xor_am, mae_pkg::op_xor_ma, mae_pkg::op_xor_ai: begin
                fn    = ((instr_op == mae_pkg::op_and_am) || (instr_op == mae_pkg::op_and_ma) ||
                         (instr_op == mae_pkg::op_and_ai)) ? mae_pkg::fn_and
                      : ((instr_op == mae_pkg::op_or_am) || (instr_op == mae_pkg::op_or_ma) ||
                         (instr_op == mae_pkg::op_or_ai)) ? mae_pkg::fn_or
                      : mae_pkg::fn_xor;
                b_imm = (instr_op == mae_pkg::op_and_ai) || (instr_op == mae_pkg::op_or_ai) ||
                        (instr_op == mae_pkg::op_xor_ai);
                dst   = ((instr_op == mae_pkg::op_and_ma) || (instr_op == mae_pkg::op_or_ma) ||
                         (instr_op == mae_pkg::op_xor_ma)) ? mae_pkg::dst_mem : mae_pkg::dst_acc;
                upd_z = 1'b1;
            end
            default: fn = mae_pkg::fn_hold;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operand fetch and write-back.

    // Addresses from the system area upward always sit in bank 0.
    assign eff_idx = (bank0 || (instr_addr >= mae_pkg::SYS_AREA)) ? {1'b0, instr_addr}
                                                                 : {bank_q, instr_addr};
    assign mem_rd  = mem[eff_idx];

    assign alu_bus.fn  = fn;
    assign alu_bus.a   = acc_q;
    assign alu_bus.b   = b_imm ? instr_imm : mem_rd;
    assign alu_bus.cin = cin;
    assign alu_bus.hin = half_carry_flag_q;

    assign start    = instr_valid && (st_q == st_ready);
    assign finish   = (st_q == st_finish);
    assign fin_word = pend_rom_q ? rom_data : prod_q;

    always_comb begin
        mem_we    = 1'b0;
        mem_widx  = eff_idx;
        mem_wdata = alu_bus.res;
        if (finish) begin
            mem_we    = 1'b1;
            mem_widx  = {1'b0, mae_pkg::R_ADDR};
            mem_wdata = fin_word[15:8];
        end else if (start && !bad) begin
            mem_we    = (dst == mae_pkg::dst_mem) || (dst == mae_pkg::dst_swap);
            mem_wdata = (dst == mae_pkg::dst_swap) ? acc_q : alu_bus.res;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_widx] <= mem_wdata;
        end
    end

    // The bank selector mirrors its memory byte so reads never see an unwritten cell.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bank_q <= mae_pkg::BANK_RESET;
        end else if (mem_we && (mem_widx == {1'b0, mae_pkg::BANK_ADDR})) begin
            bank_q <= mem_wdata[mae_pkg::BANK_BIT];
        end
    end

    always_ff @(posedge clk) begin
        dbg_data_q <= mem[dbg_idx];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing of two-cycle instructions.

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q       <= st_ready;
            ready_q    <= 1'b1;
            pend_rom_q <= 1'b0;
            prod_q     <= '0;
            rom_addr_q <= mae_pkg::ROM_ADDR_RESET;
            rom_rd_q   <= 1'b0;
        end else begin
            case (st_q)
                st_ready: begin
                    if (start && multi) begin
                        st_q       <= st_finish;
                        ready_q    <= 1'b0;
                        pend_rom_q <= (instr_op == mae_pkg::op_rtr);
                        prod_q     <= 16'(acc_q) * 16'(mem_rd);
                        rom_addr_q <= {mem[{1'b0, mae_pkg::Y_ADDR}],
                                       mem[{1'b0, mae_pkg::Z_ADDR}]};
                        rom_rd_q   <= (instr_op == mae_pkg::op_rtr);
                    end
                end
                st_finish: begin
                    st_q     <= st_ready;
                    ready_q  <= 1'b1;
                    rom_rd_q <= 1'b0;
                end
                default: st_q <= st_ready;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_q   <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            done_q   <= (start && !multi && !bad) || finish;
            reject_q <= start && bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulator and flags.

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_q <= mae_pkg::ACC_RESET;
        end else if (finish) begin
            acc_q <= fin_word[7:0];
        end else if (start && ((dst == mae_pkg::dst_acc) || (dst == mae_pkg::dst_swap))) begin
            acc_q <= alu_bus.res;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            carry_q            <= mae_pkg::FLAG_RESET;
            half_carry_flag_q  <= mae_pkg::FLAG_RESET;
            zero_result_flag_q <= mae_pkg::FLAG_RESET;
        end else if (finish) begin
            if (!pend_rom_q) begin
                zero_result_flag_q <= (prod_q[7:0] == 8'h00);
            end
        end else if (start && !bad) begin
            if (upd_c) begin
                carry_q <= alu_bus.cout;
            end
            if (upd_h) begin
                half_carry_flag_q <= alu_bus.hout;
            end
            if (upd_z) begin
                zero_result_flag_q <= (alu_bus.res == 8'h00);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_store_flags_kept: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_bzm_ma) |=>
            $stable({carry_q, half_carry_flag_q, zero_result_flag_q}) && done_q)
        else $error("Bank-0 store changed a flag.");

    chk_load_zero_set: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_bzm_am) |=>
            done_q && (zero_result_flag_q == (acc_q == 8'h00)))
        else $error("Bank-0 load zero flag wrong.");

    chk_imm_range: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_bzm_mi) && (instr_addr < mae_pkg::WREG_FIRST) |=>
            reject_q && !done_q)
        else $error("Out of range immediate move was not refused.");

    chk_exch_flags: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_exch) |=>
            $stable({carry_q, half_carry_flag_q, zero_result_flag_q}))
        else $error("Exchange changed a flag.");

    chk_table_two_cycles: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_rtr) |=>
            (rom_rd_q && !ready_q && !done_q) ##1 (ready_q && done_q && !rom_rd_q))
        else $error("Table read did not take two cycles.");

    chk_mult_timing: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_mult) |=> !ready_q ##1 (ready_q && done_q))
        else $error("Multiply did not take two cycles.");

    chk_mult_zero: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_mult) |=>
            ##1 (zero_result_flag_q == (acc_q == 8'h00)))
        else $error("Multiply zero flag does not follow the low byte.");

    chk_add_imm_carry: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_add_ai) |=>
            (carry_q == (({1'b0, $past(acc_q)} + {1'b0, $past(instr_imm)}) > 9'h0ff)) &&
            (acc_q == 8'($past(acc_q) + $past(instr_imm))))
        else $error("Immediate add ignored carry rule.");

    chk_sub_imm_carry: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_sub_ai) |=>
            (carry_q == ($past(acc_q) >= $past(instr_imm))) &&
            (acc_q == 8'($past(acc_q) - $past(instr_imm))))
        else $error("Immediate subtract carry is not no-borrow.");

    chk_logic_flags_kept: assert property (@(posedge clk) disable iff (sys_rst)
        start && (instr_op == mae_pkg::op_xor_ai) |=>
            $stable({carry_q, half_carry_flag_q}) &&
            (zero_result_flag_q == (acc_q == 8'h00)) &&
            (acc_q == ($past(acc_q) ^ $past(instr_imm))))
        else $error("Logic instruction changed carry or half carry.");
endmodule : mae_core

// >>> inc/mae_pkg.sv
// Shared constants and types of the move, arithmetic and logic execution core.
package mae_pkg;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned MEM_IDX_W = 9;
    localparam int unsigned MEM_DEPTH = 512;
    localparam int unsigned BANK_BIT  = 0;
    localparam logic [7:0]  WREG_FIRST = 8'h80;
    localparam logic [7:0]  WREG_LAST  = 8'h87;
    localparam logic [7:0]  SYS_AREA   = 8'h80;
    localparam logic [7:0]  R_ADDR     = 8'h82;
    localparam logic [7:0]  Z_ADDR     = 8'h83;
    localparam logic [7:0]  Y_ADDR     = 8'h84;
    localparam logic [7:0]  BANK_ADDR  = 8'h86;
    localparam logic [7:0]  ACC_RESET  = 8'h00;
    localparam logic        FLAG_RESET = 1'b0;
    localparam logic        BANK_RESET = 1'b0;
    localparam logic [15:0] ROM_ADDR_RESET = 16'h0000;
    localparam logic [3:0]  NIB_MAX    = 4'h9;
    localparam logic [7:0]  BCD_MAX    = 8'h99;
    localparam logic [7:0]  ADJ_LO     = 8'h06;
    localparam logic [7:0]  ADJ_HI     = 8'h60;

    typedef enum logic [5:0] {
        op_nop,
        op_mov_am, op_mov_ma, op_bzm_am, op_bzm_ma, op_mov_ai, op_bzm_mi,
        op_exch, op_bzx, op_rtr,
        op_adc_am, op_adc_ma, op_add_am, op_add_ma, op_bza_ma, op_add_ai,
        op_swb_am, op_swb_ma, op_sub_am, op_sub_ma, op_sub_ai,
        op_dadj, op_mult,
        op_and_am, op_and_ma, op_and_ai,
        op_or_am, op_or_ma, op_or_ai,
        op_xor_am, op_xor_ma, op_xor_ai
    } mae_op_t;

    typedef enum logic [2:0] {
        fn_hold, fn_pass, fn_add, fn_sub, fn_and, fn_or, fn_xor, fn_dadj
    } mae_fn_t;

    typedef enum logic [1:0] {dst_none, dst_acc, dst_mem, dst_swap} mae_dst_t;
endpackage : mae_pkg

// >>> inc/mae_alu_if.sv
// Operand and result bundle between the execution core and its ALU.
`timescale 1ns/100ps
interface mae_alu_if;
    mae_pkg::mae_fn_t fn;
    logic [7:0]       a;
    logic [7:0]       b;
    logic             cin;
    logic             hin;
    logic [7:0]       res;
    logic             cout;
    logic             hout;

    modport alu  (input fn, input a, input b, input cin, input hin,
                  output res, output cout, output hout);
    modport core (output fn, output a, output b, output cin, output hin,
                  input res, input cout, input hout);
endinterface : mae_alu_if

// >>> logic/mae_alu.sv
// Combinational 8-bit ALU with carry and nibble carry outputs.
`timescale 1ns/100ps
module mae_alu (
    mae_alu_if.alu port
);
    logic [8:0] wide;
    logic [4:0] nib;
    logic [7:0] adj;

    always_comb begin
        wide      = '0;
        nib       = '0;
        adj       = '0;
        port.res  = port.a;
        port.cout = port.cin;
        port.hout = port.hin;
        case (port.fn)
            mae_pkg::fn_pass: port.res = port.b;
            mae_pkg::fn_add: begin
                wide      = {1'b0, port.a} + {1'b0, port.b} + {8'h00, port.cin};
                nib       = {1'b0, port.a[3:0]} + {1'b0, port.b[3:0]} + {4'h0, port.cin};
                port.res  = wide[7:0];
                port.cout = wide[8];
                port.hout = nib[4];
            end
            // Subtraction adds the complement, so carry out means no borrow.
            mae_pkg::fn_sub: begin
                wide      = {1'b0, port.a} + {1'b0, ~port.b} + {8'h00, port.cin};
                nib       = {1'b0, port.a[3:0]} + {1'b0, ~port.b[3:0]} + {4'h0, port.cin};
                port.res  = wide[7:0];
                port.cout = wide[8];
                port.hout = nib[4];
            end
            mae_pkg::fn_and: port.res = port.a & port.b;
            mae_pkg::fn_or:  port.res = port.a | port.b;
            mae_pkg::fn_xor: port.res = port.a ^ port.b;
            mae_pkg::fn_dadj: begin
                if (port.hin || (port.a[3:0] > mae_pkg::NIB_MAX)) begin
                    adj = adj | mae_pkg::ADJ_LO;
                end
                if (port.cin || (port.a > mae_pkg::BCD_MAX)) begin
                    adj = adj | mae_pkg::ADJ_HI;
                end
                port.res  = port.a + adj;
                port.cout = port.cin || (port.a > mae_pkg::BCD_MAX);
            end
            default: port.res = port.a;
        endcase
    end
endmodule : mae_alu

// >>> bench/mae_core_test.sv
// Self-checking testbench for the move, arithmetic and logic execution core.
`timescale 1ns/100ps
module mae_core_test;
    logic             clk;
    logic             sys_rst;
    logic             instr_valid;
    mae_pkg::mae_op_t instr_op;
    logic [7:0]       instr_addr;
    logic [7:0]       instr_imm;
    logic [15:0]      rom_data;
    logic [8:0]       dbg_idx;
    logic             ready_q;
    logic             done_q;
    logic             reject_q;
    logic [7:0]       acc_q;
    logic             carry_q;
    logic             half_carry_flag_q;
    logic             zero_result_flag_q;
    logic [15:0]      rom_addr_q;
    logic             rom_rd_q;
    logic [7:0]       dbg_data_q;
    int               errors;
    int               checked;
    int               n;

    mae_core mae_core_i (
        .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_addr(instr_addr), .instr_imm(instr_imm), .rom_data(rom_data),
        .dbg_idx(dbg_idx), .ready_q(ready_q), .done_q(done_q), .reject_q(reject_q),
        .acc_q(acc_q), .carry_q(carry_q), .half_carry_flag_q(half_carry_flag_q),
        .zero_result_flag_q(zero_result_flag_q), .rom_addr_q(rom_addr_q),
        .rom_rd_q(rom_rd_q), .dbg_data_q(dbg_data_q)
    );

    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [2:0] flags();
        return {carry_q, half_carry_flag_q, zero_result_flag_q};
    endfunction : flags

    // Valid stays high on return, so the caller must issue the next op or call rd at once.
    task automatic run(input mae_pkg::mae_op_t op, input logic [7:0] a, input logic [7:0] i);
        instr_valid = 1'b1;
        instr_op    = op;
        instr_addr  = a;
        instr_imm   = i;
        n           = 0;
        @(negedge clk);
        while (done_q !== 1'b1 && reject_q !== 1'b1) begin
            n++;
            if (n > 4) begin
                errors++;
                end_of_test();
            end
            @(negedge clk);
        end
    endtask : run

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        instr_valid = 1'b0;
        dbg_idx     = {1'b0, a};
        @(negedge clk);
        chk(16'(dbg_data_q), 16'(exp));
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        run(mae_pkg::op_mov_ai, 8'h00, v);
        run(mae_pkg::op_mov_ma, a, 8'h00);
    endtask : wr

    // Presets carry and half carry to c through an immediate add, then runs one op.
    task automatic arith(input mae_pkg::mae_op_t op, input logic [7:0] a, input logic [7:0] m,
                         input logic c, input logic [7:0] res, input logic [2:0] f,
                         input logic to_mem);
        wr(8'h41, m);
        run(mae_pkg::op_mov_ai, 8'h00, c ? 8'hff : 8'h00);
        run(mae_pkg::op_add_ai, 8'h00, {7'h00, c});
        run(mae_pkg::op_mov_ai, 8'h00, a);
        run(op, 8'h41, m);
        chk(16'(n), 16'h0000);
        chk(16'(flags()), 16'(f));
        chk(16'(acc_q), 16'(to_mem ? a : res));
        rd(8'h41, to_mem ? res : m);
    endtask : arith

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(16'({ready_q, done_q, reject_q, rom_rd_q, flags()}), 16'h0040);
        chk({acc_q, rom_addr_q[7:0]}, 16'h0000);
        @(negedge clk);
    endtask : t_reset

    task automatic t_moves();
        wr(8'h20, 8'h5a);
        wr(8'h31, 8'h00);
        run(mae_pkg::op_mov_ai, 8'h00, 8'hff);
        run(mae_pkg::op_add_ai, 8'h00, 8'h01);
        run(mae_pkg::op_bzm_am, 8'h20, 8'h00);
        chk({acc_q, 5'h00, flags()}, 16'h5a06);
        run(mae_pkg::op_bzm_ma, 8'h30, 8'h00);
        chk({13'(n), flags()}, 16'h0006);
        run(mae_pkg::op_bzm_am, 8'h31, 8'h00);
        chk({acc_q, 5'h00, flags()}, 16'h0007);
        rd(8'h30, 8'h5a);
    endtask : t_moves

    task automatic t_imm(input logic [7:0] a, input logic ok);
        logic [2:0] f;
        wr(a, 8'h11);
        f = flags();
        run(mae_pkg::op_bzm_mi, a, 8'h99);
        chk(16'({done_q, reject_q, flags()}), 16'({ok, !ok, f}));
        rd(a, ok ? 8'h99 : 8'h11);
    endtask : t_imm

    task automatic t_xch(input mae_pkg::mae_op_t op, input logic [7:0] a);
        logic [2:0] f;
        wr(a, 8'h11);
        run(mae_pkg::op_mov_ai, 8'h00, 8'h22);
        f = flags();
        run(op, a, 8'h00);
        chk({acc_q, 5'h00, flags()}, {8'h11, 5'h00, f});
        rd(a, 8'h22);
    endtask : t_xch

    // Bank 1 selected: plain forms reach bank 1, bank-0 forms still reach bank 0.
    task automatic t_bank();
        run(mae_pkg::op_bzm_mi, 8'h86, 8'h01);
        wr(8'h21, 8'h77);
        run(mae_pkg::op_bzm_am, 8'h21, 8'h00);
        chk(16'(acc_q), 16'h0022);
        run(mae_pkg::op_mov_am, 8'h21, 8'h00);
        chk(16'(acc_q), 16'h0077);
        run(mae_pkg::op_bzx, 8'h21, 8'h00);
        chk(16'(acc_q), 16'h0022);
        run(mae_pkg::op_bzm_mi, 8'h86, 8'h00);
        rd(8'h21, 8'h77);
    endtask : t_bank

    task automatic t_table();
        logic [2:0] f;
        run(mae_pkg::op_bzm_mi, 8'h84, 8'h12);
        run(mae_pkg::op_bzm_mi, 8'h83, 8'h34);
        f = flags();
        rom_data = 16'habcd;
        run(mae_pkg::op_rtr, 8'h00, 8'h00);
        chk(16'(n), 16'h0001);
        chk(rom_addr_q, 16'h1234);
        chk({acc_q, 5'h00, flags()}, {8'hcd, 5'h00, f});
        rd(8'h82, 8'hab);
    endtask : t_table

    task automatic t_dadj();
        run(mae_pkg::op_mov_ai, 8'h00, 8'h09);
        run(mae_pkg::op_add_ai, 8'h00, 8'h08);
        run(mae_pkg::op_dadj, 8'h00, 8'h00);
        chk({acc_q, 5'h00, flags()}, 16'h1702);
        run(mae_pkg::op_mov_ai, 8'h00, 8'h99);
        run(mae_pkg::op_add_ai, 8'h00, 8'h01);
        run(mae_pkg::op_dadj, 8'h00, 8'h00);
        chk({acc_q, 5'h00, flags()}, 16'h0004);
    endtask : t_dadj

    task automatic t_mult(input logic [7:0] a, input logic [7:0] m, input logic c,
                          input logic [15:0] p, input logic [2:0] f);
        wr(8'h42, m);
        run(mae_pkg::op_mov_ai, 8'h00, c ? 8'hff : 8'h10);
        run(mae_pkg::op_add_ai, 8'h00, {7'h00, c});
        run(mae_pkg::op_mov_ai, 8'h00, a);
        run(mae_pkg::op_mult, 8'h42, 8'h00);
        chk(16'(n), 16'h0001);
        chk({acc_q, 5'h00, flags()}, {p[7:0], 5'h00, f});
        rd(8'h82, p[15:8]);
    endtask : t_mult

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk         = 1'b0;
        sys_rst     = 1'b1;
        instr_valid = 1'b0;
        instr_op    = mae_pkg::op_nop;
        instr_addr  = 8'h00;
        instr_imm   = 8'h00;
        rom_data    = 16'h0000;
        dbg_idx     = 9'h000;
        errors      = 0;
        checked     = 0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_moves();
        t_imm(8'h7f, 1'b0);
        t_imm(8'h80, 1'b1);
        t_imm(8'h87, 1'b1);
        t_imm(8'h88, 1'b0);
        t_xch(mae_pkg::op_exch, 8'h21);
        t_xch(mae_pkg::op_bzx, 8'h85);
        t_bank();
        t_table();
        arith(mae_pkg::op_adc_am, 8'h7f, 8'h80, 1'b1, 8'h00, 3'h7, 1'b0);
        arith(mae_pkg::op_adc_ma, 8'h05, 8'h0a, 1'b1, 8'h10, 3'h2, 1'b1);
        arith(mae_pkg::op_add_am, 8'h08, 8'h08, 1'b1, 8'h10, 3'h2, 1'b0);
        arith(mae_pkg::op_add_ma, 8'h80, 8'h80, 1'b0, 8'h00, 3'h5, 1'b1);
        arith(mae_pkg::op_bza_ma, 8'h30, 8'he0, 1'b0, 8'h10, 3'h4, 1'b1);
        arith(mae_pkg::op_add_ai, 8'h01, 8'hff, 1'b1, 8'h00, 3'h7, 1'b0);
        arith(mae_pkg::op_swb_am, 8'h10, 8'h01, 1'b0, 8'h0e, 3'h4, 1'b0);
        arith(mae_pkg::op_swb_ma, 8'h00, 8'h01, 1'b1, 8'hff, 3'h0, 1'b1);
        arith(mae_pkg::op_sub_am, 8'h44, 8'h44, 1'b1, 8'h00, 3'h7, 1'b0);
        arith(mae_pkg::op_sub_ma, 8'h20, 8'h30, 1'b1, 8'hf0, 3'h2, 1'b1);
        arith(mae_pkg::op_sub_ai, 8'h05, 8'h05, 1'b0, 8'h00, 3'h7, 1'b0);
        t_dadj();
        t_mult(8'h10, 8'h10, 1'b0, 16'h0100, 3'h1);
        t_mult(8'h03, 8'h05, 1'b1, 16'h000f, 3'h6);
        arith(mae_pkg::op_and_am, 8'hf0, 8'h3c, 1'b1, 8'h30, 3'h6, 1'b0);
        arith(mae_pkg::op_and_ma, 8'hf0, 8'h3c, 1'b0, 8'h30, 3'h0, 1'b1);
        arith(mae_pkg::op_and_ai, 8'h0f, 8'hf0, 1'b0, 8'h00, 3'h1, 1'b0);
        arith(mae_pkg::op_or_am, 8'hf0, 8'h3c, 1'b0, 8'hfc, 3'h0, 1'b0);
        arith(mae_pkg::op_or_ma, 8'hf0, 8'h3c, 1'b1, 8'hfc, 3'h6, 1'b1);
        arith(mae_pkg::op_or_ai, 8'hf0, 8'h3c, 1'b0, 8'hfc, 3'h0, 1'b0);
        arith(mae_pkg::op_xor_am, 8'hf0, 8'h3c, 1'b1, 8'hcc, 3'h6, 1'b0);
        arith(mae_pkg::op_xor_ma, 8'hf0, 8'h3c, 1'b0, 8'hcc, 3'h0, 1'b1);
        arith(mae_pkg::op_xor_ai, 8'h5a, 8'h5a, 1'b1, 8'h00, 3'h7, 1'b0);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        end_of_test();
    end
endmodule : mae_core_test
